// [hdl/clamp_coast_sync_control.sv]
// Purpose: clamp/freewheel/auto-offset/sync monitor/channel control bank
// Assumes: simple register port (addr, wr, wdata, rdata) synchronous to clk_sys;
//   pixel clock treated as clk_sys, syncs synchronous; hsync inputs active high
// Notes: analog circuits sit outside; this block drives their controls
//   register port is a plain strobe port: a write lands on the edge that sees reg_wr high,
//   and a read is a combinational view of the addressed register, so no wait states exist
//   unmapped addresses ignore writes and read as zero, which keeps the decode simple
//   fixed-pattern fields are stored exactly as written; keeping them right is software's job
//   the clamp timer runs on clk_sys, which doubles as the pixel clock in this model
//   placement and duration are latched at the hsync trailing edge, so a write in the
//   middle of a line only takes effect from the next line onward
//   a placement of zero starts the clamp on the cycle right after the trailing edge
//   a duration of zero suppresses the internal clamp pulse for that line entirely
//   the auto-offset strobe is one cycle wide and registered; it marks when correction runs
//   the rate counter only counts clamp starts while auto-offset is enabled
//   disabling auto-offset clears the rate counter; a rate change alone keeps the count
//   the freewheel and clamp pin paths are combinational so the pins act with no delay
//   the sync monitor output is registered and lags its source by one cycle
//   the active channel is registered on channel_sel with the same one cycle lag
//   limitation: sync presence comes from outside; this block does not detect activity
//   limitation: polarity auto-detection is outside; its results arrive on *_pol_auto
// Operation
// - freewheel source: internal window or pin
// - freewheel polarity: auto or programmed
// - programmed polarity: 0 low, 1 high
// - clamp source: internal pulse or pin
// - per-channel clamp level: ground or midscale
// - clamp starts placement periods after hsync
// - clamp lasts duration periods, reset 32
// - external clamp polarity: auto or programmed
// - programmed clamp polarity: 0 low, 1 high
// - auto-offset enable gates correction
// - auto-offset rate: 1, 16, 64, vsync
// - slicer threshold field in upper bits
// - monitor output polarity low or high
// - monitor select routes four sync sources
// - channel override: auto or programmed
// - channel select picks channel 0 or 1
`default_nettype none
`include "clamp_coast_consts.svh"
module clamp_coast_sync_control
  import clamp_coast_pkg::*;
(
  // clock and asynchronous active-low reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // sync sources of both input channels, all active high
  input wire logic horizontal_sync_ch0,
  input wire logic horizontal_sync_ch1,
  input wire logic green_embedded_sync_ch0,
  input wire logic green_embedded_sync_ch1,
  input wire logic regen_sync_ch0,
  input wire logic regen_sync_ch1,
  input wire logic filt_sync_ch0,
  input wire logic filt_sync_ch1,
  // activity flags from the sync detector, then the vsync input
  input wire logic sync_present_ch0,
  input wire logic sync_present_ch1,
  input wire logic vsync_in,
  // freewheel and external clamp sources with their detected polarities
  input wire logic fw_window_internal,
  input wire logic fw_pin,
  input wire logic fw_pol_auto,
  input wire logic ext_clamp_pin,
  input wire logic ext_clamp_pol_auto,
  // controls towards the analog front end and the sync processor
  output logic freewheel_active,
  output logic clamp_active,
  output logic [2:0] clamp_midscale,
  output logic auto_offset_strobe,
  output logic [4:0] slicer_threshold,
  output logic sync_monitor_output,
  output logic channel_sel
);

  // reset synchroniser stages
  logic rst_m_q, rst_s_q;
  // register images, one per mapped address
  logic [7:0] fwc_q, place_q, dur_q, cofs_q, test_q, emb_q, pwr_q;
  logic hs_q, vs_q, hs_fall, vs_rise;
  logic [7:0] cnt_q, place_lat_q, dur_lat_q;
  clamp_state_e st_q;
  logic [5:0] ao_cnt_q;
  logic fw_pol, cl_pol, int_clamp, ext_clamp, chan, hs_sel;
  logic mon_raw;
  mon_sel_e mon_sel;
  ao_rate_e ao_rate;

  // reset release through two flops, assertion stays asynchronous
  // only rst_s_q is used below; rst_m_q may be metastable on release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // register writes; stored as written, software keeps the fixed patterns
  // forcing the fixed bits here would hide a software error from readback,
  // so they are kept as written and reads show what software really put there
  always_ff @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      fwc_q <= `RST_FW_CLAMP_CTRL;
      place_q <= `RST_CLAMP_PLACE;
      dur_q <= `RST_CLAMP_DUR;
      cofs_q <= `RST_CLAMP_OFFSET;
      test_q <= `RST_TEST_ZERO;
      emb_q <= `RST_EMB_SYNC;
      pwr_q <= `RST_PWR_CHAN;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_FW_CLAMP_CTRL: fwc_q <= reg_wdata;
        `ADDR_CLAMP_PLACE: place_q <= reg_wdata;
        `ADDR_CLAMP_DUR: dur_q <= reg_wdata;
        `ADDR_CLAMP_OFFSET: cofs_q <= reg_wdata;
        `ADDR_TEST_ZERO: test_q <= reg_wdata;
        `ADDR_EMB_SYNC: emb_q <= reg_wdata;
        `ADDR_PWR_CHAN: pwr_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  // combinational so a read needs no wait state on the port
  always_comb begin
    case (reg_addr)
      `ADDR_FW_CLAMP_CTRL: reg_rdata = fwc_q;
      `ADDR_CLAMP_PLACE: reg_rdata = place_q;
      `ADDR_CLAMP_DUR: reg_rdata = dur_q;
      `ADDR_CLAMP_OFFSET: reg_rdata = cofs_q;
      `ADDR_TEST_ZERO: reg_rdata = test_q;
      `ADDR_EMB_SYNC: reg_rdata = emb_q;
      `ADDR_PWR_CHAN: reg_rdata = pwr_q;
      default: reg_rdata = 8'h00;
    endcase
  end

  // channel choice
  // both present or override: follow the bit; else the live one, channel 0 when neither is
  always_comb begin
    if (pwr_q[`BIT_CHAN_OVR] || (sync_present_ch0 && sync_present_ch1)) begin
      chan = pwr_q[`BIT_CHAN_SEL];
    end else begin
      chan = sync_present_ch1 && !sync_present_ch0;
    end
  end
  assign hs_sel = chan ? horizontal_sync_ch1 : horizontal_sync_ch0;

  // edge detect on the active channel hsync and on vsync
  // both flops reset to the idle low level so no false edge follows reset
  // a channel switch may look like an hsync edge; the clamp just restarts
  always_ff @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      hs_q <= 1'b0;
      vs_q <= 1'b0;
    end else begin
      hs_q <= hs_sel;
      vs_q <= vsync_in;
    end
  end
  assign hs_fall = hs_q && !hs_sel;
  assign vs_rise = vsync_in && !vs_q;

  // placement then duration
  // values latched at the edge so mid-line writes do not tear the pulse
  // the wait state counts placement cycles, then the active state counts duration
  // a new trailing edge always wins over a count in progress
  // cnt_q compares against value minus one because the first cycle is count zero
  always_ff @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      st_q <= CL_IDLE;
      cnt_q <= 8'h00;
      place_lat_q <= `RST_CLAMP_PLACE;
      dur_lat_q <= `RST_CLAMP_DUR;
    end else if (hs_fall) begin
      place_lat_q <= place_q;
      dur_lat_q <= dur_q;
      cnt_q <= 8'h00;
      st_q <= (place_q == 8'h00) ? ((dur_q == 8'h00) ? CL_IDLE : CL_ACTIVE) : CL_WAIT;
    end else begin
      case (st_q)
        CL_WAIT: begin
          if (cnt_q == place_lat_q - 8'h01) begin
            cnt_q <= 8'h00;
            st_q <= (dur_lat_q == 8'h00) ? CL_IDLE : CL_ACTIVE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        CL_ACTIVE: begin
          if (cnt_q == dur_lat_q - 8'h01) begin
            cnt_q <= 8'h00;
            st_q <= CL_IDLE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        CL_IDLE: cnt_q <= 8'h00;
        default: st_q <= CL_IDLE;
      endcase
    end
  end
  assign int_clamp = (st_q == CL_ACTIVE);

  // external clamp polarity
  // the pin is normalised to active high before the source select
  assign cl_pol = cofs_q[`BIT_EXT_CLAMP_OVR] ? cofs_q[`BIT_EXT_CLAMP_POL] : ext_clamp_pol_auto;
  assign ext_clamp = cl_pol ? ext_clamp_pin : !ext_clamp_pin;
  assign clamp_active = fwc_q[`BIT_CLAMP_SRC] ? ext_clamp : int_clamp;

  assign clamp_midscale = {fwc_q[`BIT_CLAMP_RED], fwc_q[`BIT_CLAMP_GRN], fwc_q[`BIT_CLAMP_BLU]};

  // freewheel polarity
  // the programmed bit is ignored unless the override bit is set
  assign fw_pol = fwc_q[`BIT_FW_POL_OVR] ? fwc_q[`BIT_FW_POL] : fw_pol_auto;
  assign freewheel_active = fwc_q[`BIT_FW_SRC] ? (fw_pol ? fw_pin : !fw_pin) : fw_window_internal;

  // auto-offset scheduling
  // counts clamp starts; a rate change takes effect at once and does not clear the count
  // a clamp start is the rising edge of the selected clamp, internal or pin
  // the vsync rate ignores clamps and fires one cycle after each vsync rise
  // the counter is six bits wide, enough for the slowest clamp-based rate
  assign ao_rate = ao_rate_e'(cofs_q[4:3]);
  logic clamp_q, clamp_start;
  always_ff @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      clamp_q <= 1'b0;
      ao_cnt_q <= 6'h00;
      auto_offset_strobe <= 1'b0;
    end else begin
      clamp_q <= clamp_active;
      auto_offset_strobe <= 1'b0;
      if (!cofs_q[`BIT_AUTO_OFS_EN]) begin
        ao_cnt_q <= 6'h00;
      end else begin
        case (ao_rate)
          AO_EVERY: auto_offset_strobe <= clamp_start;
          AO_16: begin
            if (clamp_start) begin
              auto_offset_strobe <= (ao_cnt_q[3:0] == `AO_DIV16);
              ao_cnt_q <= {2'b00, ao_cnt_q[3:0] + 4'h1};
            end
          end
          AO_64: begin
            if (clamp_start) begin
              auto_offset_strobe <= (ao_cnt_q == `AO_DIV64);
              ao_cnt_q <= ao_cnt_q + 6'h01;
            end
          end
          AO_VSYNC: auto_offset_strobe <= vs_rise;
          default: auto_offset_strobe <= 1'b0;
        endcase
      end
    end
  end
  assign clamp_start = clamp_active && !clamp_q;

  assign slicer_threshold = emb_q[7:3];

  // monitor source from active channel
  // the raw hsync choice reuses the channel mux of the clamp timer
  assign mon_sel = mon_sel_e'(emb_q[1:0]);
  always_comb begin
    case (mon_sel)
      MON_RAW_EMB: mon_raw = chan ? green_embedded_sync_ch1 : green_embedded_sync_ch0;
      MON_RAW_HS: mon_raw = hs_sel;
      MON_REGEN: mon_raw = chan ? regen_sync_ch1 : regen_sync_ch0;
      MON_FILT: mon_raw = chan ? filt_sync_ch1 : filt_sync_ch0;
      default: mon_raw = 1'b0;
    endcase
  end

  // monitor polarity, registered data output
  // reset level is one: idle low source seen through the default active-low setting
  always_ff @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      sync_monitor_output <= 1'b1;
      channel_sel <= 1'b0;
    end else begin
      sync_monitor_output <= emb_q[`BIT_MON_POL] ? mon_raw : !mon_raw;
      channel_sel <= chan;
    end
  end

endmodule // clamp_coast_sync_control
`default_nettype wire

// [hdl/clamp_coast_consts.svh]
// Purpose: offsets, field positions, reset values for clamp/freewheel control
// Assumes: 8-bit registers on the simple register port
// Notes: included by the package-using module, the checker and the register host
`ifndef CLAMP_COAST_CONSTS_SVH
`define CLAMP_COAST_CONSTS_SVH
`define ADDR_FW_CLAMP_CTRL 8'h18
`define ADDR_CLAMP_PLACE 8'h19
`define ADDR_CLAMP_DUR 8'h1A
`define ADDR_CLAMP_OFFSET 8'h1B
`define ADDR_TEST_ZERO 8'h1C
`define ADDR_EMB_SYNC 8'h1D
`define ADDR_PWR_CHAN 8'h1E
`define RST_FW_CLAMP_CTRL 8'h20
`define RST_CLAMP_PLACE 8'h08
`define RST_CLAMP_DUR 8'h20
`define RST_CLAMP_OFFSET 8'h5B
`define RST_TEST_ZERO 8'hFF
`define RST_EMB_SYNC 8'h78
`define RST_PWR_CHAN 8'h30
`define BIT_FW_SRC 7
`define BIT_FW_POL_OVR 6
`define BIT_FW_POL 5
`define BIT_CLAMP_SRC 4
`define BIT_CLAMP_RED 3
`define BIT_CLAMP_GRN 2
`define BIT_CLAMP_BLU 1
`define BIT_EXT_CLAMP_OVR 7
`define BIT_EXT_CLAMP_POL 6
`define BIT_AUTO_OFS_EN 5
`define BIT_MON_POL 2
`define BIT_CHAN_OVR 7
`define BIT_CHAN_SEL 6
`define AO_DIV16 4'hF
`define AO_DIV64 6'h3F
`endif

// [hdl/clamp_coast_pkg.sv]
// Purpose: shared types for clamp/freewheel control
// Assumes: nothing beyond SystemVerilog
// Notes: numbers live in the consts header
`default_nettype none
package clamp_coast_pkg;
  typedef enum logic [1:0] {
    AO_EVERY = 2'b00,
    AO_16 = 2'b01,
    AO_64 = 2'b10,
    AO_VSYNC = 2'b11
  } ao_rate_e;
  typedef enum logic [1:0] {
    MON_RAW_EMB = 2'b00,
    MON_RAW_HS = 2'b01,
    MON_REGEN = 2'b10,
    MON_FILT = 2'b11
  } mon_sel_e;
  typedef enum logic [1:0] {
    CL_IDLE = 2'b00,
    CL_WAIT = 2'b01,
    CL_ACTIVE = 2'b10
  } clamp_state_e;
endpackage : clamp_coast_pkg
`default_nettype wire

// [dv/ccs_checker.sv]
// Purpose: port-level checks of the clamp and sync control bank
// Assumes: shadow copies of the control registers track port writes
// Notes: bound into the design at the foot of this file
`default_nettype none
`include "clamp_coast_consts.svh"
module ccs_checker (
  input wire logic clk_sys, reset_n, reg_wr, vsync_in, fw_window_internal, fw_pin,
  input wire logic fw_pol_auto, ext_clamp_pin, ext_clamp_pol_auto, channel_sel,
  input wire logic freewheel_active, clamp_active, auto_offset_strobe,
  input wire logic [7:0] reg_addr, reg_wdata,
  input wire logic [2:0] clamp_midscale,
  input wire logic [4:0] slicer_threshold
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] fc_q, co_q, es_q, pc_q;
  logic [1:0] up_q;
  logic rdy, fw_pol, cl_pol;
  // polarity in use: programmed when overridden, else the detected one
  assign fw_pol = fc_q[6] ? fc_q[5] : fw_pol_auto;
  assign cl_pol = co_q[7] ? co_q[6] : ext_clamp_pol_auto;
  assign rdy = up_q == 2'h3;
  // shadows follow writes; up_q hides the two-edge reset release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fc_q <= `RST_FW_CLAMP_CTRL;
      co_q <= `RST_CLAMP_OFFSET;
      es_q <= `RST_EMB_SYNC;
      pc_q <= `RST_PWR_CHAN;
      up_q <= 2'h0;
    end else begin
      up_q <= rdy ? up_q : up_q + 2'h1;
      if (reg_wr && reg_addr == `ADDR_FW_CLAMP_CTRL) fc_q <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_CLAMP_OFFSET) co_q <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_EMB_SYNC) es_q <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_PWR_CHAN) pc_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence s_clamp_rise;
    !fc_q[4] && $rose(clamp_active);
  endsequence
  property p_fw_int; !fc_q[7] |-> freewheel_active == fw_window_internal; endproperty
  a_fw_int: assert property (p_fw_int) else $error("freewheel not window");
  property p_fw_ext; fc_q[7] |-> freewheel_active == (fw_pin ^ !fw_pol); endproperty
  a_fw_ext: assert property (p_fw_ext) else $error("freewheel pin level");
  property p_cl_ext; fc_q[4] |-> clamp_active == (ext_clamp_pin ^ !cl_pol); endproperty
  a_cl_ext: assert property (p_cl_ext) else $error("clamp pin level");
  property p_mid; clamp_midscale == fc_q[3:1]; endproperty
  a_mid: assert property (p_mid) else $error("clamp level bits");
  property p_thr; slicer_threshold == es_q[7:3]; endproperty
  a_thr: assert property (p_thr) else $error("slicer threshold");
  property p_chan; rdy && pc_q[7] |=> channel_sel == $past(pc_q[6]); endproperty
  a_chan: assert property (p_chan) else $error("channel override");
  property p_ao_all; co_q[5] && co_q[4:3] == 2'h0 ##0 s_clamp_rise |=> auto_offset_strobe; endproperty
  a_ao_all: assert property (p_ao_all) else $error("offset per clamp");
  property p_ao_vs; co_q[5] && co_q[4:3] == 2'h3 && $rose(vsync_in) |=> auto_offset_strobe; endproperty
  a_ao_vs: assert property (p_ao_vs) else $error("offset per vsync");
endmodule // ccs_checker
bind clamp_coast_sync_control ccs_checker i_chk (.*);
`default_nettype wire

// [dv/reg_host.sv]
// Purpose: host on the register port of the control bank
// Assumes: write taken at the rising edge, read data combinational
// Notes: fixed-pattern fields are forced on the way out
`default_nettype none
`include "clamp_coast_consts.svh"
module reg_host (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // one write, held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    if (a == `ADDR_FW_CLAMP_CTRL) reg_wdata[0] = 1'b0;
    if (a == `ADDR_CLAMP_OFFSET) reg_wdata[2:0] = 3'h3;
    if (a == `ADDR_TEST_ZERO) reg_wdata = 8'hFF;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata; // stale data must not look valid
  endtask
  // read sampled at the edge, like a real master
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    @(posedge clk_sys);
    d = reg_rdata;
    #1;
  endtask
endmodule // reg_host
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: self-checking bench for the clamp and sync control bank
// Assumes: inputs change 1 ns after the rising edge of clk_sys
// Notes: register rows, then clamp, offset rates, pins, monitor, channel
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic horizontal_sync_ch0 = 1'b0, horizontal_sync_ch1 = 1'b0, regen_sync_ch0 = 1'b0;
  logic green_embedded_sync_ch0 = 1'b0, green_embedded_sync_ch1 = 1'b0, regen_sync_ch1 = 1'b0;
  logic filt_sync_ch0 = 1'b0, filt_sync_ch1 = 1'b0, sync_present_ch0 = 1'b0, vsync_in = 1'b0;
  logic sync_present_ch1 = 1'b0, fw_window_internal = 1'b0, fw_pin = 1'b0, fw_pol_auto = 1'b0;
  logic ext_clamp_pin = 1'b0, ext_clamp_pol_auto = 1'b0, exp_lvl;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, freewheel_active, clamp_active, auto_offset_strobe, sync_monitor_output;
  logic channel_sel;
  logic [2:0] clamp_midscale;
  logic [4:0] slicer_threshold;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int strobes = 0;
  // {write, addr, data, expected read}
  logic [27:0] rows [12] = '{28'h0180020, 28'h0190008, 28'h01A0020, 28'h01B005B, 28'h01C00FF,
    28'h01D0078, 28'h01E0030, 28'h119A5A5, 28'h11FAA00, 28'h11C00FF, 28'h11B8083, 28'h118FFFE};
  // {0x1E value, present ch0, present ch1, 0, expected channel}
  logic [11:0] ch_rows [6] = '{12'hC01, 12'h80C, 12'h005, 12'h40D, 12'h00C, 12'h008};
  clamp_coast_sync_control i_dut (.*);
  reg_host i_host (.*);
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one hsync pulse; clamp level checked each cycle after the trailing edge
  task automatic hpulse(input int p, input int d);
    horizontal_sync_ch0 = 1'b1;
    @(posedge clk_sys);
    #1;
    horizontal_sync_ch0 = 1'b0;
    for (int k = 0; k < p + d + 2; k++) begin
      @(posedge clk_sys);
      #1;
      check("clamp_active", clamp_active, k >= p && k < p + d);
    end
  endtask
  // strobe counter and hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (auto_offset_strobe === 1'b1) strobes++;
    if (cyc == 8000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (rows[r]) begin
      if (rows[r][24]) i_host.wr(rows[r][23:16], rows[r][15:8]);
      i_host.rd(rows[r][23:16], rv);
      check("reg_rdata", rv, rows[r][7:0]);
    end
    $display("register test done");
    i_host.wr(8'h18, 8'h20);
    i_host.wr(8'h19, 8'h00);
    i_host.wr(8'h1A, 8'h00);
    hpulse(0, 0);
    i_host.wr(8'h1A, 8'h01);
    hpulse(0, 1);
    i_host.wr(8'h19, 8'h03);
    i_host.wr(8'h1A, 8'h05);
    // disabling between rates clears the rate counter
    for (int r = 0; r < 4; r++) begin
      i_host.wr(8'h1B, 8'h43);
      i_host.wr(8'h1B, 8'h63 | 8'(r << 3));
      strobes = 0;
      for (int n = 0; n < (r == 2 ? 64 : 16); n++) hpulse(3, 5);
      vsync_in = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      vsync_in = 1'b0;
      check("strobes", 8'(strobes), r == 0 ? 8'h10 : 8'h01);
    end
    $display("clamp and offset test done");
    for (int i = 0; i < 8; i++) begin
      i_host.wr(8'h18, {1'b1, i[2], i[1], 1'b1, i[2:0], 1'b0});
      i_host.wr(8'h1B, {i[2], i[1], 6'h1B});
      fw_pin = i[0];
      ext_clamp_pin = i[0];
      fw_pol_auto = !i[1];
      ext_clamp_pol_auto = !i[1];
      #1;
      exp_lvl = i[0] ^ !(i[2] ? i[1] : !i[1]);
      check("freewheel_active", freewheel_active, exp_lvl);
      check("clamp_active", clamp_active, exp_lvl);
      check("clamp_midscale", clamp_midscale, i[2:0]);
    end
    i_host.wr(8'h18, 8'h20);
    fw_window_internal = 1'b1;
    #1;
    check("freewheel_active", freewheel_active, 8'h01);
    for (int m = 0; m < 8; m++) begin
      i_host.wr(8'h1D, {5'h15, m[2:0]});
      {filt_sync_ch0, regen_sync_ch0, horizontal_sync_ch0, green_embedded_sync_ch0} = 4'h1 << m[1:0];
      {filt_sync_ch1, regen_sync_ch1, horizontal_sync_ch1, green_embedded_sync_ch1} = ~(4'h1 << m[1:0]);
      repeat (2) @(posedge clk_sys);
      #1;
      check("sync_monitor_output", sync_monitor_output, m[2]);
      check("slicer_threshold", slicer_threshold, 8'h15);
    end
    $display("pin and monitor test done");
    foreach (ch_rows[c]) begin
      i_host.wr(8'h1E, ch_rows[c][11:4]);
      {sync_present_ch0, sync_present_ch1} = ch_rows[c][3:2];
      repeat (2) @(posedge clk_sys);
      #1;
      check("channel_sel", channel_sel, ch_rows[c][0]);
    end
    $display("channel test done");
    // mid-run reset: outputs and registers return to defaults
    i_host.wr(8'h1E, 8'hC0);
    repeat (2) @(posedge clk_sys);
    #1;
    reset_n = 1'b0;
    #1;
    check("channel_sel", channel_sel, 8'h00);
    check("sync_monitor_output", sync_monitor_output, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    i_host.rd(8'h1E, rv);
    check("reg_rdata", rv, 8'h30);
    i_host.rd(8'h19, rv);
    check("reg_rdata", rv, 8'h08);
    check("channel_sel", channel_sel, 8'h00);
    $display("reset test done");
    results();
  end
endmodule // tb_top
`default_nettype wire
